// ---- hw/cpfm_top.sv ----
// four-channel pin function mux: role selection, wake-up and per-channel pin muxes
// Contract
// R01: any of four channels can be serial
// R02: pin 2 drives rts, pin 3 samples cts
// R03: dtr driven; dsr and carrier detect sampled
// R04: ring low in suspend with wake raises resume
// R05: last serial pin is ring in or enable
// R06: that choice configured, ring input by default
// R07: suspend pull-down blocks wake-up from suspend
// R08: bit-bang in two variants, same pins
// R09: bit-bang bus d0 txd pin to d7
// R10: only channels a and b have engines
// R11: engine pins: clock out, data out, data in
// R12: engine pin 3 is select output
// R13: engine pins 4 to 7 general purpose
// R14: engine serves jtag, i2c, spi, custom buses
// R15: channels c and d stay free alongside engines
// R16: one role per channel, no foreign drivers
`default_nettype none
module cpfm_top #(
   parameter int NUM_ENGINE = cpfm_pkg::CPFM_NUM_ENGINE // channels carrying an engine
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // role configuration, one-hot per channel
   input wire logic [3:0][3:0] cfg_mode_in,
   input wire logic [3:0] cfg_rs485_driver_enable_sel_in,
   // power state
   input wire logic suspend_in,
   input wire logic remote_wake_en_in,
   input wire logic suspend_pulldown_en_in,
   output logic resume_req_out,
   // role status
   output logic [3:0][3:0] chan_mode_out,
   output logic [3:0] mode_refused_out,
   // serial controllers
   input wire logic [3:0] uart_txd_in,
   input wire logic [3:0] uart_rts_n_in,
   input wire logic [3:0] uart_dtr_n_in,
   input wire logic [3:0] rs485_driver_enable_in,
   output logic [3:0] uart_rxd_out,
   output logic [3:0] uart_cts_n_out,
   output logic [3:0] uart_dsr_n_out,
   output logic [3:0] carrier_detect_n_out,
   output logic [3:0] ring_indicator_n_out,
   // bit-bang controllers
   input wire logic [3:0][7:0] bitbang_drv_in,
   input wire logic [3:0][7:0] bitbang_dir_in,
   output logic [3:0][7:0] bitbang_rd_out,
   // synchronous engines of channels a and b
   input wire logic [1:0] engine_clock_in,
   input wire logic [1:0] engine_sdo_in,
   input wire logic [1:0] engine_select_in,
   input wire logic [1:0][3:0] engine_gp_line_in,
   input wire logic [1:0][3:0] engine_gp_dir_in,
   output logic [1:0] engine_sdi_out,
   output logic [1:0][3:0] engine_gp_rd_out,
   // channel a pins
   input wire logic [7:0] chan_a_bitbang_bus_in,
   output logic [7:0] chan_a_bitbang_bus_out,
   output logic [7:0] chan_a_bitbang_bus_oe_out,
   // channel b pins
   input wire logic [7:0] chan_b_bitbang_bus_in,
   output logic [7:0] chan_b_bitbang_bus_out,
   output logic [7:0] chan_b_bitbang_bus_oe_out,
   // channel c pins
   input wire logic [7:0] chan_c_bitbang_bus_in,
   output logic [7:0] chan_c_bitbang_bus_out,
   output logic [7:0] chan_c_bitbang_bus_oe_out,
   // channel d pins
   input wire logic [7:0] chan_d_bitbang_bus_in,
   output logic [7:0] chan_d_bitbang_bus_out,
   output logic [7:0] chan_d_bitbang_bus_oe_out
);
   // the engine ports are two wide, so more engines cannot be served
   if (NUM_ENGINE < 0 || NUM_ENGINE > cpfm_pkg::CPFM_NUM_ENGINE)
   begin : g_bad_param
      $error("NUM_ENGINE out of range");
   end

   cpfm_pkg::cpfm_top_st_t st_ff; // all top state
   cpfm_pkg::cpfm_top_st_t nxt_st; // its next value
   logic [3:0][7:0] pin_in; // pins gathered by channel
   logic [3:0][7:0] pin_out; // registered pin levels
   logic [3:0][7:0] pin_oe; // registered pin enables
   logic [3:0] ring_low; // ring input asserted per channel
   logic wake_cond; // resume may be raised now

   cpfm_chan_if ifc[4] (); // controller bundles, one per channel

   // is this role legal on this channel
   function automatic logic mode_ok(input logic [3:0] req, input int chan);
      logic ok;
      ok = $onehot(req);
      if (req == cpfm_pkg::CPFM_M_ENGINE && chan >= NUM_ENGINE)
         ok = 1'h0; // engine exists on the first channels only
      return ok;
   endfunction

   // pins gathered into an array
   assign pin_in[0] = chan_a_bitbang_bus_in;
   assign pin_in[1] = chan_b_bitbang_bus_in;
   assign pin_in[2] = chan_c_bitbang_bus_in;
   assign pin_in[3] = chan_d_bitbang_bus_in;
   assign chan_a_bitbang_bus_out = pin_out[0];
   assign chan_b_bitbang_bus_out = pin_out[1];
   assign chan_c_bitbang_bus_out = pin_out[2];
   assign chan_d_bitbang_bus_out = pin_out[3];
   assign chan_a_bitbang_bus_oe_out = pin_oe[0];
   assign chan_b_bitbang_bus_oe_out = pin_oe[1];
   assign chan_c_bitbang_bus_oe_out = pin_oe[2];
   assign chan_d_bitbang_bus_oe_out = pin_oe[3];

   // per channel wiring and mux instance
   for (genvar i = 0; i < cpfm_pkg::CPFM_NUM_CHAN; i++)
   begin : g_chan
      assign ifc[i].uart_txd = uart_txd_in[i];
      assign ifc[i].uart_rts_n = uart_rts_n_in[i];
      assign ifc[i].uart_dtr_n = uart_dtr_n_in[i];
      assign ifc[i].rs485_driver_enable = rs485_driver_enable_in[i];
      assign ifc[i].bitbang_drv = bitbang_drv_in[i];
      assign ifc[i].bitbang_dir = bitbang_dir_in[i];
      assign uart_rxd_out[i] = ifc[i].uart_rxd;
      assign uart_cts_n_out[i] = ifc[i].uart_cts_n;
      assign uart_dsr_n_out[i] = ifc[i].uart_dsr_n;
      assign carrier_detect_n_out[i] = ifc[i].carrier_detect_in_n;
      assign ring_indicator_n_out[i] = ifc[i].ring_indicator_in_n;
      assign bitbang_rd_out[i] = ifc[i].bitbang_rd;
      // ring counts only in serial role with the ring input selected
      assign ring_low[i] = st_ff.mode[i] == cpfm_pkg::CPFM_M_UART
                           && !ifc[i].ring_indicator_in_n; // [R04]
      // engine hookup only where an engine exists
      if (i < NUM_ENGINE)
      begin : g_eng
         assign ifc[i].engine_clock_out = engine_clock_in[i]; // [R10] [R14]
         assign ifc[i].engine_sdo = engine_sdo_in[i];
         assign ifc[i].engine_select = engine_select_in[i];
         assign ifc[i].engine_gp_line = engine_gp_line_in[i];
         assign ifc[i].engine_gp_dir = engine_gp_dir_in[i];
      end
      else
      begin : g_no_eng
         // no engine: inputs held quiet, role never reaches the mux
         assign ifc[i].engine_clock_out = 1'h0; // [R10]
         assign ifc[i].engine_sdo = 1'h0;
         assign ifc[i].engine_select = 1'h0;
         assign ifc[i].engine_gp_line = 4'h0;
         assign ifc[i].engine_gp_dir = 4'h0;
      end
      if (i < cpfm_pkg::CPFM_NUM_ENGINE)
      begin : g_eng_rd
         // readbacks of engine inputs on the engine channels
         if (i < NUM_ENGINE)
         begin : g_live
            assign engine_sdi_out[i] = ifc[i].engine_data_in;
            assign engine_gp_rd_out[i] = ifc[i].engine_gp_rd;
         end
         else
         begin : g_dead
            assign engine_sdi_out[i] = 1'h0;
            assign engine_gp_rd_out[i] = 4'h0;
         end
      end
      cpfm_chan u_chan (
         .mclk_in(mclk_in),
         .resetn_in(resetn_in),
         .mode_in(st_ff.mode[i]),
         .rs485_driver_enable_sel_in(st_ff.rs485_driver_enable_sel[i]),
         .ctl(ifc[i]),
         .pin_in(pin_in[i]),
         .pin_out(pin_out[i]),
         .pin_oe_out(pin_oe[i])
      );
   end

   // wake-up allowed only when armed and no pull-down is applied
   assign wake_cond = suspend_in && remote_wake_en_in
                      && !suspend_pulldown_en_in; // [R04] [R07]

   // next state: role per channel, ring or enable choice, resume request
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.refused = 4'h0;
      // each channel picks its role on its own, so c and d stay free
      for (int i = 0; i < cpfm_pkg::CPFM_NUM_CHAN; i++)
      begin
         if (mode_ok(cfg_mode_in[i], i))
            nxt_st.mode[i] = cpfm_pkg::cpfm_mode_t'(cfg_mode_in[i]); // [R15] [R16]
         else
            nxt_st.refused[i] = 1'h1; // illegal request: previous role kept [R10]
      end
      // ring input unless configuration selects the enable output
      nxt_st.rs485_driver_enable_sel = cfg_rs485_driver_enable_sel_in; // [R06]
      // request held until the host leaves suspend
      if (!suspend_in)
         nxt_st.resume = 1'h0;
      if (wake_cond && |ring_low)
         nxt_st.resume = 1'h1; // [R04]
   end

   // state register; serial role and ring input after reset
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < cpfm_pkg::CPFM_NUM_CHAN; i++)
            st_ff.mode[i] <= cpfm_pkg::CPFM_M_UART; // [R01]
         st_ff.rs485_driver_enable_sel <= cpfm_pkg::CPFM_RS485_DRIVER_ENABLE_RESET; // [R06]
         st_ff.refused <= 4'h0;
         st_ff.resume <= cpfm_pkg::CPFM_RESUME_RESET;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // status outputs from flops
   assign resume_req_out = st_ff.resume;
   assign mode_refused_out = st_ff.refused;
   for (genvar i = 0; i < cpfm_pkg::CPFM_NUM_CHAN; i++)
   begin : g_stat
      assign chan_mode_out[i] = st_ff.mode[i];
   end

   // channels without an engine never hold the engine role
   AST_NO_ENGINE_CD: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R10]
      st_ff.mode[2] != cpfm_pkg::CPFM_M_ENGINE && st_ff.mode[3] != cpfm_pkg::CPFM_M_ENGINE)
      else $error("engine role on channel without engine");
   // a legal request lands in the next cycle
   AST_MODE_TAKEN: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R15]
      mode_ok(cfg_mode_in[3], 3) |=> st_ff.mode[3] == $past(cfg_mode_in[3])
         && !mode_refused_out[3])
      else $error("legal role not taken");
   // a refused request leaves the role unchanged
   AST_MODE_REFUSED: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R16]
      !mode_ok(cfg_mode_in[1], 1) |=> st_ff.mode[1] == $past(st_ff.mode[1])
         && mode_refused_out[1])
      else $error("illegal role not refused");
   // ring low while armed in suspend raises resume next cycle
   AST_RESUME_SET: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R04]
      wake_cond && ring_low[3] |=> resume_req_out)
      else $error("resume not raised");
   // resume never rises while a pull-down is applied
   AST_NO_WAKE_PULLDOWN: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R07]
      $rose(resume_req_out) |-> !$past(suspend_pulldown_en_in) && $past(suspend_in))
      else $error("wake despite pull-down");
   // selected enable output hides the ring input
   AST_RING_DEFAULT: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R06]
      st_ff.rs485_driver_enable_sel[2] |-> ring_indicator_n_out[2] && !ring_low[2])
      else $error("ring seen while pin is output");
endmodule
`default_nettype wire

// ---- hw/cpfm_pkg.sv ----
// shared constants, pin map, modes and state types of the channel pin function mux
`default_nettype none
package cpfm_pkg;
   // channel geometry
   localparam int CPFM_NUM_CHAN = 4;
   localparam int CPFM_PINS = 8;
   localparam int CPFM_ENGINE_GP = 4;
   localparam int CPFM_NUM_ENGINE = 2;
   // serial port pin positions
   localparam int P_TXD = 0;
   localparam int P_RXD = 1;
   localparam int P_RTS = 2;
   localparam int P_CTS = 3;
   localparam int P_DTR = 4;
   localparam int P_DSR = 5;
   localparam int P_DCD = 6;
   localparam int P_RI = 7;
   // engine pin positions
   localparam int P_ECLK = 0;
   localparam int P_EDO = 1;
   localparam int P_EDI = 2;
   localparam int P_ESEL = 3;
   localparam int P_GP0 = 4;
   // idle and reset levels
   localparam logic [7:0] CPFM_PINS_IDLE = 8'h00;
   localparam logic CPFM_LINE_IDLE = 1'h1;
   localparam logic [3:0] CPFM_RS485_DRIVER_ENABLE_RESET = 4'h0;
   localparam logic CPFM_RESUME_RESET = 1'h0;
   // pin roles of one channel, one-hot
   typedef enum logic [3:0] {
      CPFM_M_UART = 4'h1,
      CPFM_M_BB_ASYNC = 4'h2,
      CPFM_M_BB_SYNC = 4'h4,
      CPFM_M_ENGINE = 4'h8
   } cpfm_mode_t;
   // per channel pin state
   typedef struct packed {
      logic [7:0] meta;
      logic [7:0] sync;
      logic [7:0] drv;
      logic [7:0] oe;
   } cpfm_chan_st_t;
   // both sync stages reset to the idle line level, so no false ring follows reset
   localparam cpfm_chan_st_t CPFM_CHAN_RESET = '{8'hFF, 8'hFF, 8'h00, 8'h00};
   // top level state
   typedef struct packed {
      cpfm_mode_t [3:0] mode;
      logic [3:0] rs485_driver_enable_sel;
      logic [3:0] refused;
      logic resume;
   } cpfm_top_st_t;
endpackage
`default_nettype wire

// ---- hw/cpfm_chan_if.sv ----
// controller-side signals of one channel between the top and the pin mux
`default_nettype none
interface cpfm_chan_if;
   // serial port
   logic uart_txd, uart_rts_n, uart_dtr_n, rs485_driver_enable;
   logic uart_rxd, uart_cts_n, uart_dsr_n, carrier_detect_in_n, ring_indicator_in_n;
   // bit-bang bus
   logic [7:0] bitbang_drv, bitbang_dir, bitbang_rd;
   // synchronous engine
   logic engine_clock_out, engine_sdo, engine_select, engine_data_in;
   logic [3:0] engine_gp_line, engine_gp_dir, engine_gp_rd;
   modport ctrl (
      output uart_txd, uart_rts_n, uart_dtr_n, rs485_driver_enable,
      output bitbang_drv, bitbang_dir,
      output engine_clock_out, engine_sdo, engine_select, engine_gp_line, engine_gp_dir,
      input uart_rxd, uart_cts_n, uart_dsr_n, carrier_detect_in_n, ring_indicator_in_n,
      input bitbang_rd, engine_data_in, engine_gp_rd
   );
   modport mux (
      input uart_txd, uart_rts_n, uart_dtr_n, rs485_driver_enable,
      input bitbang_drv, bitbang_dir,
      input engine_clock_out, engine_sdo, engine_select, engine_gp_line, engine_gp_dir,
      output uart_rxd, uart_cts_n, uart_dsr_n, carrier_detect_in_n, ring_indicator_in_n,
      output bitbang_rd, engine_data_in, engine_gp_rd
   );
endinterface
`default_nettype wire

// ---- hw/cpfm_chan.sv ----
// pin mux of one channel: input synchronisers and registered pin drivers
`default_nettype none
module cpfm_chan (
   // clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // role chosen by the top
   input wire cpfm_pkg::cpfm_mode_t mode_in,
   input wire logic rs485_driver_enable_sel_in,
   // controller side
   cpfm_chan_if.mux ctl,
   // pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_out
);
   cpfm_pkg::cpfm_chan_st_t st_ff; // whole channel state
   cpfm_pkg::cpfm_chan_st_t nxt_st; // its next value

   // next state: only the active role may place a driver on a pin
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.meta = pin_in; // first stage, read only by the second
      nxt_st.sync = st_ff.meta;
      nxt_st.drv = cpfm_pkg::CPFM_PINS_IDLE; // undriven unless the role claims it [R16]
      nxt_st.oe = cpfm_pkg::CPFM_PINS_IDLE;
      case (mode_in)
         cpfm_pkg::CPFM_M_UART:
         begin
            nxt_st.drv[cpfm_pkg::P_TXD] = ctl.uart_txd; // [R01]
            nxt_st.oe[cpfm_pkg::P_TXD] = 1'h1;
            nxt_st.drv[cpfm_pkg::P_RTS] = ctl.uart_rts_n; // [R02]
            nxt_st.oe[cpfm_pkg::P_RTS] = 1'h1;
            nxt_st.drv[cpfm_pkg::P_DTR] = ctl.uart_dtr_n; // [R03]
            nxt_st.oe[cpfm_pkg::P_DTR] = 1'h1;
            // last pin drives the line driver enable only when selected
            if (rs485_driver_enable_sel_in)
            begin
               nxt_st.drv[cpfm_pkg::P_RI] = ctl.rs485_driver_enable; // [R05]
               nxt_st.oe[cpfm_pkg::P_RI] = 1'h1;
            end
         end
         cpfm_pkg::CPFM_M_BB_ASYNC, cpfm_pkg::CPFM_M_BB_SYNC:
         begin
            // both variants share one pin map, d0 on the transmit pin
            nxt_st.drv = ctl.bitbang_drv; // [R08] [R09]
            nxt_st.oe = ctl.bitbang_dir;
         end
         cpfm_pkg::CPFM_M_ENGINE:
         begin
            nxt_st.drv[cpfm_pkg::P_ECLK] = ctl.engine_clock_out; // [R11]
            nxt_st.oe[cpfm_pkg::P_ECLK] = 1'h1;
            nxt_st.drv[cpfm_pkg::P_EDO] = ctl.engine_sdo;
            nxt_st.oe[cpfm_pkg::P_EDO] = 1'h1;
            nxt_st.drv[cpfm_pkg::P_ESEL] = ctl.engine_select; // [R12] [R14]
            nxt_st.oe[cpfm_pkg::P_ESEL] = 1'h1;
            nxt_st.drv[cpfm_pkg::P_GP0 +: cpfm_pkg::CPFM_ENGINE_GP] = ctl.engine_gp_line; // [R13]
            nxt_st.oe[cpfm_pkg::P_GP0 +: cpfm_pkg::CPFM_ENGINE_GP] = ctl.engine_gp_dir;
         end
         default:
         begin
            nxt_st.oe = cpfm_pkg::CPFM_PINS_IDLE; // unknown role: all pins released
         end
      endcase
   end

   // state register; pins float while in reset
   always_ff @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         st_ff <= cpfm_pkg::CPFM_CHAN_RESET;
      else
         st_ff <= nxt_st;
   end

   // pin drivers come straight from flops
   assign pin_out = st_ff.drv;
   assign pin_oe_out = st_ff.oe;
   // readbacks from the second stage only
   assign ctl.uart_rxd = st_ff.sync[cpfm_pkg::P_RXD]; // [R01]
   assign ctl.uart_cts_n = st_ff.sync[cpfm_pkg::P_CTS]; // [R02]
   assign ctl.uart_dsr_n = st_ff.sync[cpfm_pkg::P_DSR]; // [R03]
   assign ctl.carrier_detect_in_n = st_ff.sync[cpfm_pkg::P_DCD];
   // ring input reads idle while that pin is an output
   assign ctl.ring_indicator_in_n = rs485_driver_enable_sel_in ? cpfm_pkg::CPFM_LINE_IDLE
                                                 : st_ff.sync[cpfm_pkg::P_RI]; // [R05]
   assign ctl.bitbang_rd = st_ff.sync; // [R09]
   assign ctl.engine_data_in = st_ff.sync[cpfm_pkg::P_EDI]; // [R11]
   assign ctl.engine_gp_rd = st_ff.sync[cpfm_pkg::P_GP0 +: cpfm_pkg::CPFM_ENGINE_GP];

   // serial role drives txd, rts and dtr one cycle on
   AST_UART_DRIVE: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R01]
      mode_in == cpfm_pkg::CPFM_M_UART |=> pin_oe_out[cpfm_pkg::P_TXD]
         && pin_out[cpfm_pkg::P_TXD] == $past(ctl.uart_txd)
         && pin_oe_out[cpfm_pkg::P_RTS] && pin_oe_out[cpfm_pkg::P_DTR]
         && !pin_oe_out[cpfm_pkg::P_CTS] && !pin_oe_out[cpfm_pkg::P_RXD])
      else $error("serial pins wrong");
   AST_RTS_DTR: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R02]
      mode_in == cpfm_pkg::CPFM_M_UART |=> pin_out[cpfm_pkg::P_RTS] == $past(ctl.uart_rts_n)
         && pin_out[cpfm_pkg::P_DTR] == $past(ctl.uart_dtr_n))
      else $error("handshake output wrong");
   AST_INPUT_SYNC: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R03]
      $past(resetn_in, 2) |-> ctl.uart_dsr_n == $past(pin_in[cpfm_pkg::P_DSR], 2)
         && ctl.uart_rxd == $past(pin_in[cpfm_pkg::P_RXD], 2))
      else $error("input not two flops late");
   AST_RS485_DRIVER_ENABLE_PIN: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R05]
      mode_in == cpfm_pkg::CPFM_M_UART |=> pin_oe_out[cpfm_pkg::P_RI] == $past(rs485_driver_enable_sel_in)
         && (!$past(rs485_driver_enable_sel_in)
             || pin_out[cpfm_pkg::P_RI] == $past(ctl.rs485_driver_enable)))
      else $error("last pin role wrong");
   AST_BITBANG: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R09]
      mode_in inside {cpfm_pkg::CPFM_M_BB_ASYNC, cpfm_pkg::CPFM_M_BB_SYNC}
         |=> pin_out == $past(ctl.bitbang_drv) && pin_oe_out == $past(ctl.bitbang_dir))
      else $error("bit-bang bus wrong");
   AST_ENGINE_PINS: assert property (@(posedge mclk_in) disable iff (!resetn_in) // [R11]
      mode_in == cpfm_pkg::CPFM_M_ENGINE |=> pin_oe_out[3:0] == 4'hB
         && pin_out[cpfm_pkg::P_ECLK] == $past(ctl.engine_clock_out)
         && pin_out[cpfm_pkg::P_ESEL] == $past(ctl.engine_select)
         && pin_oe_out[7:4] == $past(ctl.engine_gp_dir))
      else $error("engine pins wrong");
endmodule
`default_nettype wire

// ---- test/cpfm_pins_model.sv ----
// far-side peripheral model: drives every pin the device leaves undriven
`default_nettype none
module cpfm_pins_model (
   // device pin drive
   input wire logic [3:0][7:0] dev_out_in,
   input wire logic [3:0][7:0] dev_oe_in,
   // levels the peripherals want on their lines
   input wire logic [3:0][7:0] ext_in,
   // resolved pin levels
   output logic [3:0][7:0] pin_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // peripheral backs off wherever the device drives, so no contention
   // ring line is pulled low through ext_in bit 7 while suspended
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         pin_out[i] = (dev_oe_in[i] & dev_out_in[i]) | (~dev_oe_in[i] & ext_in[i]);
   end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench of the channel pin function mux
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // one pending expectation
   typedef struct {int due; int sel; logic [31:0] msk; logic [31:0] exp;} cpfm_note_t;
   logic mclk_in, resetn_in, suspend_in, remote_wake_en_in, suspend_pulldown_en_in;
   logic resume_req_out;
   logic [3:0][3:0] cfg_mode_in, chan_mode_out;
   logic [3:0] cfg_rs485_driver_enable_sel_in, mode_refused_out, uart_txd_in, uart_rts_n_in, uart_dtr_n_in;
   logic [3:0] rs485_driver_enable_in, uart_rxd_out, uart_cts_n_out, uart_dsr_n_out;
   logic [3:0] carrier_detect_n_out, ring_indicator_n_out;
   logic [3:0][7:0] bitbang_drv_in, bitbang_dir_in, bitbang_rd_out, ext, pin, pout, poe;
   logic [1:0] engine_clock_in, engine_sdo_in, engine_select_in, engine_sdi_out;
   logic [1:0][3:0] engine_gp_line_in, engine_gp_dir_in, engine_gp_rd_out;
   logic [63:0] rnd;
   cpfm_note_t notes[$];
   int cyc = 0;
   int miscompares = 0;
   int total_checks = 0;
   int seed = 31612;
   cpfm_top u_cpfm_top (.mclk_in, .resetn_in, .cfg_mode_in, .cfg_rs485_driver_enable_sel_in, .suspend_in,
      .remote_wake_en_in, .suspend_pulldown_en_in, .resume_req_out, .chan_mode_out,
      .mode_refused_out, .uart_txd_in, .uart_rts_n_in, .uart_dtr_n_in, .rs485_driver_enable_in,
      .uart_rxd_out, .uart_cts_n_out, .uart_dsr_n_out, .carrier_detect_n_out,
      .ring_indicator_n_out, .bitbang_drv_in, .bitbang_dir_in, .bitbang_rd_out,
      .engine_clock_in, .engine_sdo_in, .engine_select_in, .engine_gp_line_in,
      .engine_gp_dir_in, .engine_sdi_out, .engine_gp_rd_out,
      .chan_a_bitbang_bus_in(pin[0]), .chan_a_bitbang_bus_out(pout[0]),
      .chan_a_bitbang_bus_oe_out(poe[0]), .chan_b_bitbang_bus_in(pin[1]),
      .chan_b_bitbang_bus_out(pout[1]), .chan_b_bitbang_bus_oe_out(poe[1]),
      .chan_c_bitbang_bus_in(pin[2]), .chan_c_bitbang_bus_out(pout[2]),
      .chan_c_bitbang_bus_oe_out(poe[2]), .chan_d_bitbang_bus_in(pin[3]),
      .chan_d_bitbang_bus_out(pout[3]), .chan_d_bitbang_bus_oe_out(poe[3]));
   cpfm_pins_model u_cpfm_pins_model (.dev_out_in(pout), .dev_oe_in(poe), .ext_in(ext),
      .pin_out(pin));
   // free-running 20 MHz clock
   initial
   begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   // cycle count that dates the notes
   always @(posedge mclk_in)
      cyc <= cyc + 1;
   // observed groups: 0..3 pins of a channel, then readbacks, modes
   function automatic logic [31:0] look(int s);
      case (s)
         4: look = bitbang_rd_out;
         5: look = {12'h0, ring_indicator_n_out, carrier_detect_n_out, uart_dsr_n_out,
            uart_cts_n_out, uart_rxd_out};
         6: look = {22'h0, engine_gp_rd_out, engine_sdi_out};
         7: look = {11'h0, chan_mode_out, mode_refused_out, resume_req_out};
         default: look = {16'h0, poe[s], pout[s]};
      endcase
   endfunction
   // expected {oe, out} of one channel for its requested role
   function automatic logic [15:0] exp_pins(int i);
      logic t;
      t = cfg_rs485_driver_enable_sel_in[i];
      case (cfg_mode_in[i])
         4'h1: exp_pins = {t, 7'h15, t & rs485_driver_enable_in[i], 2'h0, uart_dtr_n_in[i],
            1'b0, uart_rts_n_in[i], 1'b0, uart_txd_in[i]};
         4'h8: exp_pins = {engine_gp_dir_in[i], 4'hB, engine_gp_line_in[i], engine_select_in[i],
            1'b0, engine_sdo_in[i], engine_clock_in[i]};
         default: exp_pins = {bitbang_dir_in[i], bitbang_drv_in[i]};
      endcase
   endfunction
   // single comparison point
   task automatic check(logic [31:0] seen, logic [31:0] want);
      total_checks++;
      if (seen !== want)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   // results settle within six cycles while inputs are held
   task automatic note(int s, logic [31:0] m, logic [31:0] e);
      notes.push_back('{cyc + 6, s, m, e});
   endtask
   // watcher: compares every due note against the outputs, oldest first
   always @(negedge mclk_in)
      while (notes.size() > 0 && notes[0].due <= cyc)
      begin
         check(look(notes[0].sel) & notes[0].msk, notes[0].exp & notes[0].msk);
         void'(notes.pop_front());
      end
   task automatic hold();
      repeat (8) @(posedge mclk_in);
   endtask
   // note every expectation that follows from the present inputs
   task automatic expect_all();
      logic [15:0] e;
      logic [31:0] lv;
      logic [19:0] rb;
      for (int i = 0; i < 4; i++)
      begin
         e = exp_pins(i);
         // out only compared where driven; undriven out level is left open
         note(i, {16'h0, 8'hFF, e[15:8]}, {16'h0, e});
         lv[8*i +: 8] = (e[15:8] & e[7:0]) | (~e[15:8] & ext[i]);
         rb[i] = ext[i][1];
         rb[4+i] = ext[i][3];
         rb[8+i] = ext[i][5];
         rb[12+i] = ext[i][6];
         rb[16+i] = ext[i][7] | cfg_rs485_driver_enable_sel_in[i];
      end
      note(4, '1, lv);
      if (cfg_mode_in === 16'h1111)
         note(5, 32'hFFFFF, {12'h0, rb});
      if (cfg_mode_in[1:0] === 8'h88)
         note(6, 32'h3FF, {22'h0, lv[15:12], lv[7:4], ext[1][2], ext[0][2]});
      note(7, 32'h1FFFE0, {11'h0, cfg_mode_in, 5'h0});
   endtask
   // one random trial in the given roles
   task automatic shake(logic [15:0] m);
      @(posedge mclk_in);
      rnd = {$random(seed), $random(seed)};
      cfg_mode_in <= m;
      cfg_rs485_driver_enable_sel_in <= rnd[3:0];
      {uart_txd_in, uart_rts_n_in, uart_dtr_n_in, rs485_driver_enable_in} <= rnd[19:4];
      {engine_clock_in, engine_sdo_in, engine_select_in} <= rnd[25:20];
      {engine_gp_line_in, engine_gp_dir_in} <= rnd[41:26];
      {bitbang_drv_in, bitbang_dir_in} <= rnd;
      ext <= $random(seed);
      #1;
      expect_all();
      hold();
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // guard against a hang, far beyond the planned run
   initial
   begin
      #500000;
      miscompares++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      resetn_in = 1'b0;
      cfg_mode_in = 16'h1111;
      {cfg_rs485_driver_enable_sel_in, suspend_in, remote_wake_en_in, suspend_pulldown_en_in} = '0;
      {uart_txd_in, uart_rts_n_in, uart_dtr_n_in, rs485_driver_enable_in} = '0;
      {bitbang_drv_in, bitbang_dir_in, engine_clock_in, engine_sdo_in, engine_select_in} = '0;
      {engine_gp_line_in, engine_gp_dir_in} = '0;
      ext = '1;
      @(posedge mclk_in);
      // in reset: serial roles, ring input, nothing driven
      note(7, 32'h1FFFFF, {11'h0, 16'h1111, 5'h0});
      for (int i = 0; i < 4; i++)
         note(i, 32'hFFFF, 32'h0);
      repeat (7) @(posedge mclk_in);
      resetn_in <= 1'b1;
      hold();
      shake(16'h1111);
      shake(16'h1111);
      shake(16'h2488);
      shake(16'h4288);
      shake(16'h1188);
      // illegal requests on b, c and d: roles kept, refusal flagged
      @(posedge mclk_in);
      cfg_mode_in <= 16'h8308;
      #1;
      note(7, 32'h1FFFFF, {11'h0, 16'h1188, 4'hE, 1'b0});
      hold();
      for (int k = 0; k < 12; k++)
      begin
         rnd = {$random(seed), $random(seed)};
         shake({4'h1 << (rnd[7:6] % 3), 4'h1 << (rnd[5:4] % 3), 4'h1 << rnd[3:2],
            4'h1 << rnd[1:0]});
      end
      // wake: ring of d low in suspend; last case selects the enable instead
      for (int k = 0; k < 5; k++)
      begin
         @(posedge mclk_in);
         cfg_mode_in <= 16'h1111;
         cfg_rs485_driver_enable_sel_in <= {k == 4, 3'h0};
         {remote_wake_en_in, suspend_pulldown_en_in} <= (k == 4) ? 2'h2 : k[1:0];
         suspend_in <= 1'b1;
         ext <= 32'h7FFFFFFF;
         #1;
         note(7, 32'h1, {31'h0, k == 2});
         hold();
         @(posedge mclk_in);
         suspend_in <= 1'b0;
         ext <= '1;
         #1;
         note(7, 32'h1, 32'h0);
         hold();
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
